// [rrc_pkg.sv]
// Shared constants, types and field layout of the radio receive control block.
package rrc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] REG_STATE = 8'h02;
  localparam logic [7:0] REG_PHY_STAT = 8'h06;
  localparam logic [7:0] REG_ENERGY = 8'h07;
  localparam logic [7:0] REG_CTRL2 = 8'h0c;
  localparam logic [7:0] REG_SYNC_THR = 8'h15;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int FCS_OK_BIT = 7;
  localparam int SAFE_BIT = 7;
  localparam int DIS_BIT = 7;
  localparam int LVL_MSB = 3;
  localparam int CMD_MSB = 4;
  localparam logic [7:0] SYNC_THR_RESET = 8'h00;
  localparam logic [7:0] SYNC_THR_WMASK = 8'h8f;
  localparam logic [7:0] SYNC_THR_RSV = 8'h70;
  localparam logic [7:0] REG_ZERO = 8'h00;

  // ****************************************
  // State commands written to the command field
  // ****************************************
  localparam logic [4:0] CMD_GO_OFF = 5'h08;
  localparam logic [4:0] CMD_PLL_ON = 5'h09;
  localparam logic [4:0] CMD_RX_ON = 5'h06;
  localparam logic [4:0] CMD_AACK_ON = 5'h16;

  // ****************************************
  // Receive thresholds and tolerances
  // ****************************************
  localparam int FREQ_TOL_PPM = 120;
  localparam logic signed [7:0] STRENGTH_BASE_DBM = 8'sha6;
  localparam logic signed [7:0] THRES_STEP_DB = 8'sh03;
  localparam logic [3:0] LVL_OFF = 4'h0;
  localparam logic [3:0] LVL_ONE = 4'h1;

  // ****************************************
  // Frame buffer geometry
  // ****************************************
  localparam int FB_DEPTH = 128;
  localparam logic [6:0] FB_FIRST = 7'h00;
  localparam logic [6:0] FB_LAST = 7'h7f;
  localparam logic [6:0] FB_STEP = 7'h01;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_PLL = 3'b001,
    ST_RX = 3'b010,
    ST_AACK = 3'b011,
    ST_BUSY = 3'b100,
    ST_BUSY_AACK = 3'b101
  } rrc_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } rrc_bus_type;

  typedef struct packed {
    logic shr;
    logic signed [7:0] rssi;
    logic signed [11:0] foffs;
  } rrc_sync_type;

  typedef struct packed {
    logic valid;
    logic fcs_ok;
    logic [7:0] lqi;
    logic [7:0] energy;
  } rrc_end_type;

endpackage

// [rrc_frame_store.sv]
// Frame buffer storage: one write port for the receiver, one read port for the host.
`timescale 1ns/1ps
module rrc_frame_store
  import rrc_pkg::*;
(
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data
);

  // Both ports are independent, so the host may read while a frame lands.
  logic [7:0] mem [FB_DEPTH];

  // Receiver side write.
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Host side read, data one cycle after the strobe.
  always_ff @(posedge clock) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// [rrc_receive_control.sv]
// Receive control: state commands, frame detection, buffer fill and status registers.
// Summary of operation
// - Store frame, then append link quality byte.
// - Quality byte readable once frame-done pulses.
// - Latch frequency offset, correct rest of frame.
// - Pulse receive-start when a frame begins.
// - Pulse frame-done when a frame completes.
// - Update energy and checksum status per frame.
// - Receive command accepted from off or pll.
// - Auto-ack receive command from off or pll.
// - Signals under threshold never start demodulation.
// - Safe mode holds receive until frame read.
// - Protection only for frames with good checksum.
// - Detector disable blocks new sync headers.
// - Disable spares ongoing frame, ignores threshold.
// - Threshold is base plus three dB steps.
// - Zero level accepts every valid frame.
// - Sync threshold: reserved bits zero, reset zero.
// - Frame buffer spans 0x00 to 0x7f.
// - New frame during host read flags underrun.
`timescale 1ns/1ps
module rrc_receive_control
  import rrc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire rrc_bus_type bus,
  output logic [7:0] rdata,
  input wire logic fb_rd_en,
  input wire logic [6:0] fb_rd_addr,
  output logic [7:0] fb_rd_data,
  input wire logic fb_sel_n,
  input wire rrc_sync_type sync,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire rrc_end_type rx_end,
  output logic rx_start_irq,
  output logic frame_done_irq,
  output logic buffer_underrun_irq,
  output logic signed [11:0] freq_correction,
  output logic detect_enable,
  output rrc_state_type rx_state
);

  // ****************************************
  // Threshold arithmetic
  // ****************************************

  // Signed threshold in dBm for a nonzero level; nine bits avoid wrap at level 15.
  function automatic logic signed [8:0] threshold_of(input logic [3:0] lvl);
    logic signed [8:0] steps;
    steps = $signed({5'h00, lvl - LVL_ONE}) * $signed({1'b0, THRES_STEP_DB});
    threshold_of = $signed({STRENGTH_BASE_DBM[7], STRENGTH_BASE_DBM}) + steps;
  endfunction

  // ****************************************
  // State and registers
  // ****************************************
  rrc_state_type state_r, state_nxt;
  logic [7:0] sync_thr_r;
  logic safe_r;
  logic [7:0] energy_r;
  logic fcs_ok_r;
  logic protect_r, protect_nxt;
  logic reading_r;
  logic [6:0] wptr_r;
  logic signed [11:0] foffs_r;
  logic [7:0] rdata_r;
  logic start_irq_r, done_irq_r, ur_irq_r;

  // ****************************************
  // Decoding
  // ****************************************
  wire [3:0] level = sync_thr_r[LVL_MSB:0];
  wire detect_dis = sync_thr_r[DIS_BIT];
  wire listening = (state_r == ST_RX) || (state_r == ST_AACK);
  wire busy = (state_r == ST_BUSY) || (state_r == ST_BUSY_AACK);
  wire idle_ready = (state_r == ST_OFF) || (state_r == ST_PLL);
  wire wr_state = bus.we && (bus.addr == REG_STATE);
  wire wr_ctrl2 = bus.we && (bus.addr == REG_CTRL2);
  wire wr_sync = bus.we && (bus.addr == REG_SYNC_THR);
  wire [4:0] cmd = bus.wdata[CMD_MSB:0];
  wire signed [8:0] rssi_ext = {sync.rssi[7], sync.rssi};

  // Zero level skips the strength check altogether.
  wire strong_enough = (level == LVL_OFF) || (rssi_ext > threshold_of(level));
  // Disable works alone, regardless of level, and only gates new frames.
  wire det_en = listening && !detect_dis && !protect_r;
  wire frame_start = sync.shr && det_en && strong_enough;
  wire frame_end = busy && rx_end.valid;
  wire host_reading = !fb_sel_n;

  // Buffer write: payload bytes, then the quality byte in the end cycle.
  wire fb_wr_en = busy && (rx_byte_valid || rx_end.valid);
  wire [7:0] fb_wr_data = rx_end.valid ? rx_end.lqi : rx_byte;
  wire [6:0] wptr_inc = (wptr_r == FB_LAST) ? wptr_r : wptr_r + FB_STEP;

  // Host read multiplexer; unmapped offsets read as zero.
  wire [7:0] rd_mux =
    (bus.addr == REG_STATE) ? {5'h00, state_r} :
    (bus.addr == REG_PHY_STAT) ? {fcs_ok_r, 7'h00} :
    (bus.addr == REG_ENERGY) ? energy_r :
    (bus.addr == REG_CTRL2) ? {safe_r, 7'h00} :
    (bus.addr == REG_SYNC_THR) ? sync_thr_r : REG_ZERO;

  // ****************************************
  // Next-state logic
  // ****************************************

  // Commands during a frame are ignored so a reception always runs to its end.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF, ST_PLL: begin
        if (wr_state && cmd == CMD_RX_ON) begin
          state_nxt = ST_RX;
        end else if (wr_state && cmd == CMD_AACK_ON) begin
          state_nxt = ST_AACK;
        end else if (wr_state && cmd == CMD_PLL_ON) begin
          state_nxt = ST_PLL;
        end else if (wr_state && cmd == CMD_GO_OFF) begin
          state_nxt = ST_OFF;
        end
      end
      ST_RX, ST_AACK: begin
        if (frame_start) begin
          state_nxt = (state_r == ST_RX) ? ST_BUSY : ST_BUSY_AACK;
        end else if (wr_state && cmd == CMD_PLL_ON && !protect_r) begin
          state_nxt = ST_PLL;
        end else if (wr_state && cmd == CMD_GO_OFF && !protect_r) begin
          state_nxt = ST_OFF;
        end
      end
      ST_BUSY: begin
        if (rx_end.valid) begin
          state_nxt = ST_RX;
        end
      end
      ST_BUSY_AACK: begin
        if (rx_end.valid) begin
          state_nxt = ST_AACK;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  // Protection arms only on a good checksum and drops once the host finishes reading.
  always_comb begin
    protect_nxt = protect_r;
    if (!safe_r) begin
      protect_nxt = 1'b0;
    end else if (frame_end) begin
      protect_nxt = rx_end.fcs_ok;
    end else if (reading_r && fb_sel_n) begin
      protect_nxt = 1'b0;
    end
  end

  // ****************************************
  // Clocked processes
  // ****************************************

  // Receive state.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ST_OFF;
      protect_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      protect_r <= protect_nxt;
    end
  end

  // Host read tracking: a read burst ends when the select returns high.
  always_ff @(posedge clock) begin
    if (srst) begin
      reading_r <= 1'b0;
    end else begin
      reading_r <= host_reading && (reading_r || fb_rd_en);
    end
  end

  // Software registers.
  always_ff @(posedge clock) begin
    if (srst) begin
      sync_thr_r <= SYNC_THR_RESET;
      safe_r <= 1'b0;
    end else begin
      if (wr_sync) begin
        sync_thr_r <= bus.wdata & SYNC_THR_WMASK;
      end
      if (wr_ctrl2) begin
        safe_r <= bus.wdata[SAFE_BIT];
      end
    end
  end

  // Per-frame status, captured when the frame closes.
  always_ff @(posedge clock) begin
    if (srst) begin
      energy_r <= REG_ZERO;
      fcs_ok_r <= 1'b0;
    end else if (frame_end) begin
      energy_r <= rx_end.energy;
      fcs_ok_r <= rx_end.fcs_ok;
    end
  end

  // Frequency offset is taken once at sync and held through the frame.
  always_ff @(posedge clock) begin
    if (srst) begin
      foffs_r <= 12'sh000;
    end else if (frame_start) begin
      foffs_r <= sync.foffs;
    end
  end

  // Write pointer saturates so an overlong frame cannot wrap over its own start.
  always_ff @(posedge clock) begin
    if (srst || frame_start) begin
      wptr_r <= FB_FIRST;
    end else if (fb_wr_en) begin
      wptr_r <= wptr_inc;
    end
  end

  // Event pulses; frame-done follows the quality byte write by one cycle.
  always_ff @(posedge clock) begin
    if (srst) begin
      start_irq_r <= 1'b0;
      done_irq_r <= 1'b0;
      ur_irq_r <= 1'b0;
    end else begin
      start_irq_r <= frame_start;
      done_irq_r <= frame_end;
      ur_irq_r <= frame_start && host_reading;
    end
  end

  // Register read data, valid only in the cycle after the strobe.
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_r <= REG_ZERO;
    end else begin
      rdata_r <= bus.re ? rd_mux : REG_ZERO;
    end
  end

  // ****************************************
  // Frame buffer
  // ****************************************
  rrc_frame_store u_store (
    .clock(clock),
    .wr_en(fb_wr_en),
    .wr_addr(wptr_r),
    .wr_data(fb_wr_data),
    .rd_en(fb_rd_en),
    .rd_addr(fb_rd_addr),
    .rd_data(fb_rd_data)
  );

  // Outputs.
  assign rdata = rdata_r;
  assign rx_start_irq = start_irq_r;
  assign frame_done_irq = done_irq_r;
  assign buffer_underrun_irq = ur_irq_r;
  assign freq_correction = foffs_r;
  assign detect_enable = det_en;
  assign rx_state = state_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence frame_open_s;
    listening && sync.shr && !detect_dis && !protect_r && strong_enough;
  endsequence

  sequence frame_close_s;
    busy && rx_end.valid;
  endsequence

  lqi_append_a: assert property (frame_close_s |-> fb_wr_en && fb_wr_data == rx_end.lqi)
    else $error("quality byte not written at frame end");
  done_after_lqi_a: assert property (frame_close_s |=> frame_done_irq && !busy)
    else $error("frame done pulse missing");
  start_pulse_a: assert property (frame_open_s |=> rx_start_irq && busy ##1 !rx_start_irq)
    else $error("receive start pulse wrong");
  freq_hold_a: assert property (busy && $past(busy) |-> $stable(freq_correction))
    else $error("frequency correction changed mid frame");
  below_thr_a: assert property (listening && sync.shr && level != LVL_OFF
    && rssi_ext <= threshold_of(level) |=> !rx_start_irq)
    else $error("weak signal started a frame");
  zero_level_a: assert property (listening && sync.shr && level == LVL_OFF && !detect_dis
    && !protect_r |=> busy)
    else $error("zero level rejected a frame");
  disable_block_a: assert property (detect_dis && !busy |=> !rx_start_irq)
    else $error("disabled detector started a frame");
  disable_spare_a: assert property (busy && detect_dis && !rx_end.valid |=> busy)
    else $error("disable aborted an ongoing frame");
  status_load_a: assert property (frame_close_s |=> energy_r == $past(rx_end.energy)
    && fcs_ok_r == $past(rx_end.fcs_ok))
    else $error("frame status not captured");
  rx_cmd_a: assert property (idle_ready && wr_state && cmd == CMD_RX_ON |=> state_r == ST_RX)
    else $error("receive command not taken");
  aack_cmd_a: assert property (idle_ready && wr_state && cmd == CMD_AACK_ON
    |=> state_r == ST_AACK)
    else $error("auto-ack receive command not taken");
  protect_hold_a: assert property (protect_r && sync.shr |=> !rx_start_irq)
    else $error("protected frame overwritten");
  bad_fcs_a: assert property (frame_close_s and !rx_end.fcs_ok |=> !protect_r)
    else $error("bad checksum frame protected");
  rsv_zero_a: assert property ((sync_thr_r & SYNC_THR_RSV) == REG_ZERO)
    else $error("reserved threshold bits set");
  underrun_a: assert property (frame_open_s and !fb_sel_n |=> buffer_underrun_irq)
    else $error("underrun not flagged");

endmodule

// [rrc_demod_model.sv]
// Demodulator stand-in that feeds sync headers, payload bytes and frame ends.
`timescale 1ns/1ps
module rrc_demod_model
  import rrc_pkg::*;
(
  input wire logic clock,
  output rrc_sync_type sync,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output rrc_end_type rx_end
);
  // ****************************************
  // Frame handed over by the bench
  // ****************************************
  logic [7:0] data_q[$];
  rrc_sync_type hdr;
  rrc_end_type tail;
  logic slow = 1'b0;
  logic pend = 1'b0;
  logic gap = 1'b0;
  int step = 0;

  // Start values so the receiver never samples an unknown.
  initial begin
    sync = '0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    rx_end = '0;
  end

  // Idle cycles show inverted leftovers, so a stale value never looks valid.
  // Slow mode idles one cycle before every byte and before the frame end.
  always @(posedge clock) begin
    sync <= {1'b0, ~sync.rssi, ~sync.foffs};
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_end <= {1'b0, ~rx_end.fcs_ok, ~rx_end.lqi, ~rx_end.energy};
    if (pend && step == 0) begin
      sync <= hdr;
      step <= 1;
    end else if (step > 0 && slow && !gap) begin
      gap <= 1'b1;
    end else if (step > 0 && step <= data_q.size()) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= data_q[step-1];
      step <= step + 1;
      gap <= 1'b0;
    end else if (step > 0) begin
      rx_end <= tail;
      step <= 0;
      gap <= 1'b0;
      pend <= 1'b0;
    end
  end

  // Queues one frame: header first, then bytes, then the end strobe.
  task automatic send(input rrc_sync_type h, input rrc_end_type t, input logic s);
    hdr = h;
    tail = t;
    slow = s;
    pend = 1'b1;
  endtask
endmodule

// [rrc_receive_control_tb.sv]
// Self-checking bench for the receive control block against a behavioural reference.
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH %0t %s", $time, m); end end
module rrc_receive_control_tb
  import rrc_pkg::*;
;
  // ****************************************
  // Signals and reference state
  // ****************************************
  logic clock = 1'b0;
  logic srst = 1'b1;
  rrc_bus_type bus = '0;
  logic fb_rd_en = 1'b0;
  logic [6:0] fb_rd_addr = 7'h00;
  logic fb_sel_n = 1'b1;
  logic [7:0] rdata, fb_rd_data, rx_byte;
  rrc_sync_type sync;
  rrc_end_type rx_end;
  logic rx_byte_valid, rx_start_irq, frame_done_irq, buffer_underrun_irq, detect_enable;
  logic signed [11:0] freq_correction;
  rrc_state_type rx_state;
  int bad_count = 0;
  int checked = 0;
  int n_start = 0, n_done = 0, n_ur = 0, e_start = 0, e_done = 0, e_ur = 0;
  int st = 0, lvl = 0, dis = 0, safe = 0, prot = 0, i = 0;
  logic [7:0] buf_q[$];
  logic signed [11:0] e_foffs = 12'sh000;
  logic [7:0] e_energy = 8'h00;
  logic e_fcs = 1'b0;

  always #10 clock = ~clock;

  // Pulses last one cycle, so they are tallied here and compared later.
  always @(posedge clock) begin
    if (rx_start_irq === 1'b1) n_start <= n_start + 1;
    if (frame_done_irq === 1'b1) n_done <= n_done + 1;
    if (buffer_underrun_irq === 1'b1) n_ur <= n_ur + 1;
  end

  rrc_receive_control u_rrc_receive_control (.clock(clock), .srst(srst), .bus(bus),
    .rdata(rdata), .fb_rd_en(fb_rd_en), .fb_rd_addr(fb_rd_addr), .fb_rd_data(fb_rd_data),
    .fb_sel_n(fb_sel_n), .sync(sync), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_end(rx_end), .rx_start_irq(rx_start_irq), .frame_done_irq(frame_done_irq),
    .buffer_underrun_irq(buffer_underrun_irq), .freq_correction(freq_correction),
    .detect_enable(detect_enable), .rx_state(rx_state));

  rrc_demod_model u_rrc_demod_model (.clock(clock), .sync(sync),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_end(rx_end));

  // ****************************************
  // Bus, buffer and frame tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clock);
    bus.we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                    input string s);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clock);
    bus.re <= 1'b0;
    #1 `CHK(rdata & m, e, s)
  endtask

  task automatic cmd(input logic [4:0] c);
    if (!(prot && (c == CMD_PLL_ON || c == CMD_GO_OFF))) begin
      case (c)
        CMD_GO_OFF: st = 0;
        CMD_PLL_ON: st = 1;
        CMD_RX_ON: st = 2;
        default: st = 3;
      endcase
    end
    wr(REG_STATE, {3'b000, c});
    #1 `CHK(rx_state, 3'(st), "state after command")
  endtask

  // A host read burst with chip select low; its release lifts protection.
  task automatic read_buf();
    @(posedge clock);
    fb_sel_n <= 1'b0;
    for (int k = 0; k < buf_q.size(); k++) begin
      @(posedge clock);
      fb_rd_en <= 1'b1;
      fb_rd_addr <= 7'(k);
      @(posedge clock);
      fb_rd_en <= 1'b0;
      #1 `CHK(fb_rd_data, buf_q[k], "buffer byte")
    end
    @(posedge clock);
    fb_sel_n <= 1'b1;
    if (safe != 0) prot = 0;
  endtask

  task automatic frame(input int rssi, input int n, input logic fcs, input logic sel_n);
    rrc_sync_type h;
    rrc_end_type t;
    logic acc;
    h = '{shr: 1'b1, rssi: 8'(rssi), foffs: 12'($urandom)};
    t = '{valid: 1'b1, fcs_ok: fcs, lqi: 8'($urandom), energy: 8'($urandom)};
    acc = st >= 2 && dis == 0 && prot == 0 && (lvl == 0 || rssi > -90 + 3 * (lvl - 1));
    u_rrc_demod_model.data_q.delete();
    for (int k = 0; k < n; k++) u_rrc_demod_model.data_q.push_back(8'($urandom));
    @(posedge clock);
    fb_sel_n <= sel_n;
    u_rrc_demod_model.send(h, t, 1'($urandom));
    for (int k = 0; k < 500 && u_rrc_demod_model.pend; k++) @(posedge clock);
    if (u_rrc_demod_model.pend) begin
      bad_count++;
      conclude();
    end
    repeat (3) @(posedge clock);
    fb_sel_n <= 1'b1;
    if (acc) begin
      e_start++;
      e_done++;
      e_ur += sel_n ? 0 : 1;
      buf_q = u_rrc_demod_model.data_q;
      buf_q.push_back(t.lqi);
      e_foffs = h.foffs;
      e_energy = t.energy;
      e_fcs = fcs;
      prot = (safe != 0 && fcs) ? 1 : 0;
    end
    #1 `CHK(n_start, e_start, "start count")
    `CHK(n_done, e_done, "done count")
    `CHK(n_ur, e_ur, "underrun count")
    `CHK(rx_state, 3'(st), "state after frame")
    `CHK(freq_correction, e_foffs, "offset latch")
    rd(REG_ENERGY, e_energy, 8'hff, "energy");
    rd(REG_PHY_STAT, {e_fcs, 7'h00}, 8'h80, "checksum flag");
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h7a38dc91));
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    rd(REG_SYNC_THR, SYNC_THR_RESET, 8'hff, "threshold reset");
    rd(REG_STATE, 8'h00, 8'hff, "state reset");
    rd(8'h33, 8'h00, 8'hff, "unmapped read");
    wr(REG_SYNC_THR, 8'hff);
    rd(REG_SYNC_THR, SYNC_THR_WMASK, 8'hff, "reserved bits");
    wr(REG_SYNC_THR, 8'h00);
    $display("test registers done");
    frame(-40, 4, 1'b1, 1'b1);
    cmd(CMD_RX_ON);
    `CHK(detect_enable, 1'b1, "armed")
    frame(-40, 5, 1'b1, 1'b1);
    read_buf();
    frame(-60, 3, 1'b0, 1'b0);
    $display("test basic receive done");
    // Each level probes exactly at the threshold and one dB above it.
    for (int j = 0; j < 4; j++) begin
      lvl = (j == 0) ? 1 : (j == 1) ? 14 : (j == 2) ? 15 : int'($urandom_range(2, 13));
      wr(REG_SYNC_THR, 8'(lvl));
      frame(-90 + 3 * (lvl - 1), 3, 1'b1, 1'b1);
      frame(-89 + 3 * (lvl - 1), 3, 1'b1, 1'b1);
    end
    lvl = 0;
    wr(REG_SYNC_THR, 8'h00);
    frame(-128, 3, 1'b1, 1'b1);
    $display("test threshold done");
    // Disabling mid-frame must spare the frame already running.
    fork
      frame(-50, 8, 1'b1, 1'b1);
      begin
        repeat (3) @(posedge clock);
        wr(REG_SYNC_THR, 8'h8f);
      end
    join
    dis = 1;
    lvl = 15;
    `CHK(detect_enable, 1'b0, "disarmed")
    frame(-10, 3, 1'b1, 1'b1);
    wr(REG_SYNC_THR, 8'h00);
    dis = 0;
    lvl = 0;
    frame(-70, 3, 1'b1, 1'b1);
    $display("test detector disable done");
    cmd(CMD_PLL_ON);
    cmd(CMD_AACK_ON);
    frame(-45, 4, 1'b1, 1'b1);
    wr(REG_CTRL2, 8'h80);
    safe = 1;
    rd(REG_CTRL2, 8'h80, 8'h80, "safe bit");
    frame(-45, 4, 1'b1, 1'b1);
    cmd(CMD_PLL_ON);
    frame(-45, 4, 1'b1, 1'b1);
    read_buf();
    frame(-45, 4, 1'b0, 1'b1);
    frame(-45, 4, 1'b1, 1'b1);
    read_buf();
    wr(REG_CTRL2, 8'h00);
    safe = 0;
    cmd(CMD_GO_OFF);
    cmd(CMD_RX_ON);
    $display("test protection done");
    for (i = 0; i < 8; i++) begin
      lvl = $urandom_range(0, 15);
      wr(REG_SYNC_THR, 8'(lvl));
      frame($urandom_range(0, 90) - 100, $urandom_range(1, 20), 1'($urandom), 1'($urandom));
    end
    $display("test random frames done");
    conclude();
  end

  // Cuts a hang short well inside the cycle budget.
  initial begin
    #1500000;
    bad_count++;
    conclude();
  end
endmodule
